//--- src/sarb_core.sv
/*
 * control and byte readout of a 10-bit successive approximation converter.
 * assumes an 8-bit processor bus on the strobe pins and an analog front end
 * that compares the input against dac_code.
 */
//
// Function
// - a conversion lasts 80 to 90 converter clock periods from start to result.
// - negative input at or above positive input gives an all-zero result.
// - first byte read drives result bits 9..2 on data lines 7..0.
// - second byte read drives bits 1,0 on lines 7,6 and zeros below.
// - chip select and write low together hold reset; start follows release.
// - ten comparisons msb first over 80 clocks, result moves to output latch.
// - result transfer sets completion flag and drives conversion_done_n low.
// - chip select and read low clear the flag and enable the data lines.
`timescale 1ns/1ps
module sarb_core
  import sarb_pkg::*;
(
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // pins from the bus and the comparator
  input  wire sarb_pkg::sarb_pins_s  pins_in,
  // comparator trial code
  output logic      [9:0]            dac_code,
  // bus outputs
  output logic      [7:0]            data_line,
  output logic                       data_line_oe,
  output logic                       conversion_done_n
);
  import sarb_pkg::*;

  // ****************************************************************
  // pin synchronisers: change counts once second and third agree
  // ****************************************************************
  logic [4:0] s1_reg;
  logic [4:0] s2_reg;
  logic [4:0] s3_reg;
  logic [4:0] filt_reg;
  sarb_pins_s pin_f;

  for (genvar i = 0; i < 5; i++) begin : g_sync
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        s1_reg[i]   <= PIN_IDLE[i];
        s2_reg[i]   <= PIN_IDLE[i];
        s3_reg[i]   <= PIN_IDLE[i];
        filt_reg[i] <= PIN_IDLE[i];
      end else begin
        s1_reg[i]   <= pins_in[i];
        s2_reg[i]   <= s1_reg[i];
        s3_reg[i]   <= s2_reg[i];
        filt_reg[i] <= (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : filt_reg[i];
      end
    end
  end
  assign pin_f = filt_reg;

  // ****************************************************************
  // converter clock enable
  // ****************************************************************
  logic [5:0] div_reg;
  wire        conv_tick;

  assign conv_tick = (div_reg == DIV_LAST);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_reg <= '0;
    end else begin
      div_reg <= conv_tick ? 6'h00 : div_reg + 6'h01;
    end
  end

  // ****************************************************************
  // conversion sequencer
  // ****************************************************************
  sarb_state_e state_reg;
  sarb_state_e state_next;
  logic [6:0]  tck_reg;
  logic [9:0]  trial_reg;
  wire         start_req;
  wire         read_act;
  wire         bit_end;
  wire  [9:0]  cur_mask;
  wire  [9:0]  keep_mask;
  wire  [9:0]  trial_next;
  wire         fifo_in_ready;
  wire         fifo_push;
  wire  [9:0]  fifo_in_data;
  wire         sar_clear;

  assign start_req  = !pin_f.cs_n && !pin_f.wr_n;
  assign read_act   = !pin_f.cs_n && !pin_f.rd_n;
  assign bit_end    = conv_tick && (tck_reg[2:0] == BIT_LAST);
  assign cur_mask   = TRIAL_MSB >> tck_reg[6:3];
  assign keep_mask  = pin_f.cmp_above ? cur_mask : RESULT_ZERO;
  assign trial_next = (trial_reg & ~cur_mask) | keep_mask | (cur_mask >> 1);
  assign sar_clear  = (state_reg != ST_CONV) || start_req;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: state_next = ST_IDLE;
      ST_HOLD: state_next = ST_WAIT;
      ST_WAIT: begin
        if (conv_tick && fifo_in_ready) begin
          state_next = ST_CONV;
        end
      end
      ST_CONV: begin
        if (conv_tick && tck_reg == CONV_LAST) begin
          state_next = ST_XFER;
        end
      end
      ST_XFER: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
    if (start_req) begin
      state_next = ST_HOLD;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      tck_reg   <= '0;
      trial_reg <= TRIAL_MSB;
    end else begin
      state_reg <= state_next;
      if (sar_clear) begin
        tck_reg   <= '0;
        trial_reg <= TRIAL_MSB;
      end else if (conv_tick) begin
        tck_reg <= tck_reg + 7'h01;
        if (bit_end) begin
          trial_reg <= trial_next;
        end
      end
    end
  end

  assign dac_code     = trial_reg;
  assign fifo_push    = (state_reg == ST_XFER);
  assign fifo_in_data = pin_f.neg_ge_pos ? RESULT_ZERO : trial_reg;

  // ****************************************************************
  // result fifo and output latch
  // ****************************************************************
  wire        fifo_out_valid;
  wire  [9:0] fifo_out_data;
  wire        latch_load;
  logic [9:0] latch_reg;
  logic       done_reg;
  logic       sel_reg;
  logic       read_q_reg;
  logic [7:0] data_reg;
  logic       oe_reg;
  wire        read_end;
  wire  [7:0] byte_mux;

  sarb_fifo #(
    .WIDTH (RES_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (!read_act),
    .out_data  (fifo_out_data)
  );

  assign latch_load = fifo_out_valid && !read_act;
  assign read_end   = read_q_reg && !read_act;
  assign byte_mux   = sel_reg ? {latch_reg[1:0], LOW_FILL} : latch_reg[9:2];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      latch_reg  <= RESULT_ZERO;
      done_reg   <= 1'b0;
      sel_reg    <= 1'b0;
      read_q_reg <= 1'b0;
      data_reg   <= '0;
      oe_reg     <= 1'b0;
    end else begin
      read_q_reg <= read_act;
      data_reg   <= byte_mux;
      oe_reg     <= read_act;
      if (latch_load) begin
        latch_reg <= fifo_out_data;
      end
      if (latch_load) begin
        done_reg <= 1'b1;
      end else if (read_act || start_req) begin
        done_reg <= 1'b0;
      end
      if (start_req) begin
        sel_reg <= 1'b0;
      end else if (read_end) begin
        sel_reg <= 1'b1;
      end
    end
  end

  assign data_line         = data_reg;
  assign data_line_oe      = oe_reg;
  assign conversion_done_n = !done_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [15:0] len_reg;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      len_reg <= '0;
    end else if (state_reg == ST_HOLD || (state_reg == ST_WAIT && !fifo_in_ready)) begin
      len_reg <= '0;
    end else if (len_reg != 16'hffff) begin
      len_reg <= len_reg + 16'h0001;
    end
  end

  a_conv_len_bound: assert property (@(posedge ref_clk) disable iff (rst)
    fifo_push |-> (len_reg >= CONV_MIN_CYC && len_reg <= CONV_MAX_CYC))
    else $error("conversion length outside 80 to 90 converter clocks");
  a_neg_zero_code: assert property (@(posedge ref_clk) disable iff (rst)
    fifo_push && pin_f.neg_ge_pos |-> fifo_in_data == RESULT_ZERO)
    else $error("negative input at or above positive gave nonzero code");
  a_first_byte_map: assert property (@(posedge ref_clk) disable iff (rst)
    read_act && !sel_reg && $stable(latch_reg) |=> data_line == $past(latch_reg[9:2]))
    else $error("first byte does not carry bits 9 to 2");
  a_second_byte_map: assert property (@(posedge ref_clk) disable iff (rst)
    read_act && sel_reg |=> data_line == {latch_reg[1:0], 6'h00})
    else $error("second byte does not carry bits 1 and 0");
  a_hold_in_reset: assert property (@(posedge ref_clk) disable iff (rst)
    start_req |=> state_reg == ST_HOLD && tck_reg == 7'h00 && !fifo_push)
    else $error("conversion ran while select and write were low");
  a_msb_first_trial: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(state_reg == ST_CONV) |-> trial_reg == 10'h200)
    else $error("conversion did not start with the msb trial");
  a_done_on_load: assert property (@(posedge ref_clk) disable iff (rst)
    latch_load |=> !conversion_done_n ##1
      (!conversion_done_n || $past(read_act) || $past(start_req)))
    else $error("completion flag not set on latch transfer");
  a_read_clears: assert property (@(posedge ref_clk) disable iff (rst)
    read_act ##1 read_act |-> conversion_done_n && data_line_oe)
    else $error("read did not clear the flag or enable the data lines");
  a_byte_advance: assert property (@(posedge ref_clk) disable iff (rst)
    read_end && !start_req |=> sel_reg ##0 (start_req || !$past(start_req)))
    else $error("byte selector did not advance after a read");
  a_byte_restart: assert property (@(posedge ref_clk) disable iff (rst)
    start_req |=> !sel_reg)
    else $error("byte selector not reset at conversion start");

endmodule

//--- src/sarb_pkg.sv
/*
 * shared constants and carriers of the converter control and byte readout.
 * assumes one 100 MHz reference clock; the converter clock is an enable pulse
 * derived from it.
 */
package sarb_pkg;

  // ****************************************************************
  // clocking
  // ****************************************************************
  localparam int unsigned REF_CLK_KHZ  = 100000;
  localparam int unsigned CONV_MIN_KHZ = 200;
  localparam int unsigned CONV_MAX_KHZ = 2600;
  localparam int unsigned CONV_CLK_KHZ = 2000;
  localparam int unsigned CONV_DIV     = REF_CLK_KHZ / CONV_CLK_KHZ;
  localparam logic [5:0]  DIV_LAST     = 6'(CONV_DIV - 1);

  // ****************************************************************
  // conversion timing, in converter clock periods; CONV_MIN_CYC and CONV_MAX_CYC in ref_clk cycles
  // ****************************************************************
  localparam int unsigned RES_BITS      = 10;
  localparam int unsigned TICKS_PER_BIT = 8;
  localparam int unsigned CONV_MIN_TCK  = 80;
  localparam int unsigned CONV_MAX_TCK  = 90;
  localparam logic [6:0]  CONV_LAST     = 7'(RES_BITS * TICKS_PER_BIT - 1);
  localparam logic [2:0]  BIT_LAST      = 3'(TICKS_PER_BIT - 1);
  localparam int unsigned CONV_MIN_CYC  = CONV_MIN_TCK * CONV_DIV;
  localparam int unsigned CONV_MAX_CYC  = CONV_MAX_TCK * CONV_DIV;

  // ****************************************************************
  // values after reset and fixed codes
  // ****************************************************************
  localparam logic [9:0] TRIAL_MSB   = 10'h200;
  localparam logic [9:0] RESULT_ZERO = 10'h000;
  localparam logic [5:0] LOW_FILL    = 6'h00;
  localparam logic [4:0] PIN_IDLE    = 5'h1c;
  localparam int unsigned FIFO_DEPTH = 32;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic cmp_above;
    logic neg_ge_pos;
  } sarb_pins_s;

  typedef logic [RES_BITS-1:0] sarb_word_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HOLD = 3'b001,
    ST_WAIT = 3'b010,
    ST_CONV = 3'b011,
    ST_XFER = 3'b100
  } sarb_state_e;

endpackage

//--- src/sarb_fifo.sv
/*
 * result fifo between the approximation logic and the output latch.
 * assumes both sides on ref_clk; valid/ready on each side.
 */
`timescale 1ns/1ps
module sarb_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 32
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  wire              push;
  wire              pop;
  wire              full;
  wire              empty;

  // ****************************************************************
  // status
  // ****************************************************************
  assign full      = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                     (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty     = (wr_ptr_reg == rd_ptr_reg);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;
  assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

  // ****************************************************************
  // storage
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
      rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
    end
  end

endmodule

//--- testbench/sarb_host_model.sv
/*
 * processor bus host and comparator stand-in facing sarb_core.
 * assumes ref_clk; pins change only by non-blocking assignment at its rising edge.
 */
`timescale 1ns/1ps
module sarb_host_model
  import sarb_pkg::*;
(
  // clock
  input  wire logic           ref_clk,
  // device outputs
  input  wire logic [9:0]     dac_code,
  input  wire logic           data_line_oe,
  // analog stand-in
  input  wire logic [9:0]     target,
  input  wire logic           neg_flag,
  // bus and comparator pins
  output sarb_pkg::sarb_pins_s pins
);
  initial pins = PIN_IDLE;

  // ****************************************
  // comparator
  // ****************************************
  always @(posedge ref_clk) begin
    pins.cmp_above  <= (target >= dac_code);
    pins.neg_ge_pos <= neg_flag;
  end

  // ****************************************
  // bus cycles
  // ****************************************
  task automatic start(input int hold);
    @(posedge ref_clk);
    pins.cs_n <= 1'b0;
    pins.wr_n <= 1'b0;
    repeat (hold) @(posedge ref_clk);
    pins.wr_n <= 1'b1;
    pins.cs_n <= 1'b1;
  endtask

  task automatic read_byte();
    int n;
    n = 0;
    @(posedge ref_clk);
    pins.cs_n <= 1'b0;
    pins.rd_n <= 1'b0;
    while (data_line_oe !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    pins.cs_n <= 1'b1;
    pins.rd_n <= 1'b1;
    n = 0;
    while (data_line_oe !== 1'b0 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  task automatic park(input int hold);
    @(posedge ref_clk);
    pins.cs_n <= 1'b0;
    pins.wr_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    pins.wr_n <= 1'b1;
    pins.rd_n <= 1'b0;
    repeat (hold) @(posedge ref_clk);
    pins.cs_n <= 1'b1;
    pins.rd_n <= 1'b1;
  endtask
endmodule

//--- testbench/tb_top.sv
/*
 * self-checking bench of sarb_core; its result fifo is reached through it.
 * assumes 100 MHz ref_clk and active-high asynchronous rst.
 */
`timescale 1ns/1ps
module tb_top;
  import sarb_pkg::*;
  logic       ref_clk, rst, neg_flag, oe_d;
  sarb_pins_s pins;
  logic [9:0] dac_code, target;
  logic [7:0] data_line;
  logic       data_line_oe, conversion_done_n;
  logic [9:0] exp_q[$];
  int         errors, compares;

  sarb_core sarb_core_inst (.ref_clk(ref_clk), .rst(rst), .pins_in(pins),
    .dac_code(dac_code), .data_line(data_line), .data_line_oe(data_line_oe),
    .conversion_done_n(conversion_done_n));
  sarb_host_model sarb_host_model_inst (.ref_clk(ref_clk), .dac_code(dac_code),
    .data_line_oe(data_line_oe), .target(target), .neg_flag(neg_flag), .pins(pins));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ****************************************
  // result watcher
  // ****************************************
  always @(posedge ref_clk) begin
    oe_d <= data_line_oe;
    if (data_line_oe === 1'b1 && oe_d !== 1'b1 && exp_q.size() > 0) begin
      check({2'b00, data_line}, exp_q.pop_front());
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  task automatic run_conv(input logic [9:0] t, input logic neg, input int hold, input bit abort);
    int         cnt;
    logic [9:0] e;
    cnt = 0;
    e = neg ? RESULT_ZERO : t;
    @(posedge ref_clk);
    target <= t;
    neg_flag <= neg;
    if (abort) begin
      sarb_host_model_inst.start(2);
      repeat (1000) @(posedge ref_clk);
    end
    sarb_host_model_inst.start(hold);
    while (conversion_done_n !== 1'b0 && cnt < 5000) begin
      @(posedge ref_clk);
      cnt++;
    end
    check(10'(cnt >= CONV_MIN_CYC && cnt <= CONV_MAX_CYC), 10'h001);
    exp_q.push_back({2'b00, e[9:2]});
    exp_q.push_back({2'b00, e[1:0], LOW_FILL});
    exp_q.push_back({2'b00, e[1:0], LOW_FILL});
    repeat (3) sarb_host_model_inst.read_byte();
    check(10'(exp_q.size()), 10'h000);
    check({9'h000, conversion_done_n}, 10'h001);
    $display("test conversion %h done", t);
  endtask

  task automatic park_test();
    int         cnt;
    logic [9:0] t;
    cnt = 0;
    t = 10'($urandom);
    @(posedge ref_clk);
    target <= t;
    neg_flag <= 1'b0;
    sarb_host_model_inst.park(4300);
    check({9'h000, conversion_done_n}, 10'h001);
    while (conversion_done_n !== 1'b0 && cnt < 20) begin
      @(posedge ref_clk);
      cnt++;
    end
    check(10'(cnt < 20), 10'h001);
    exp_q.push_back({2'b00, t[1:0], LOW_FILL});
    exp_q.push_back({2'b00, t[1:0], LOW_FILL});
    repeat (2) sarb_host_model_inst.read_byte();
    check(10'(exp_q.size()), 10'h000);
    $display("test parked result done");
  endtask

  initial begin
    rst = 1'b1;
    target = 10'h000;
    neg_flag = 1'b0;
    errors = 0;
    compares = 0;
    void'($urandom(8));
    repeat (12) @(posedge ref_clk);
    check(dac_code, TRIAL_MSB);
    check({data_line_oe, 8'h00, conversion_done_n}, 10'h001);
    rst <= 1'b0;
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      run_conv((i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : 10'($urandom),
               i == 2, (i == 4) ? 300 : 2 + i, i == 3);
    end
    park_test();
    finish_test();
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    errors++;
    finish_test();
  end
endmodule
